// [pkg/eac_pkg.sv]
`default_nettype none
package eac_pkg;

  // ==========================================
  // field positions
  localparam int EAC_MODE_HI = 5;
  localparam int EAC_MODE_LO = 3;
  localparam int EAC_REG_HI = 2;
  localparam int EAC_REG_LO = 0;
  localparam int EAC_IX_DA_BIT = 15;
  localparam int EAC_IX_NUM_HI = 14;
  localparam int EAC_IX_NUM_LO = 12;
  localparam int EAC_IX_LONG_BIT = 11;
  localparam int EAC_IX_SCALE_HI = 10;
  localparam int EAC_IX_SCALE_LO = 9;
  localparam int EAC_FULL_BIT = 8;
  localparam int EAC_BASE_SUP_BIT = 7;
  localparam int EAC_IX_SUP_BIT = 6;
  localparam int EAC_BD_HI = 5;
  localparam int EAC_BD_LO = 4;
  localparam int EAC_INDIR_HI = 2;
  localparam int EAC_INDIR_LO = 0;

  // ==========================================
  // mode and submode codes
  localparam logic [2:0] EAC_M_DREG = 3'h0;
  localparam logic [2:0] EAC_M_AREG = 3'h1;
  localparam logic [2:0] EAC_M_IND = 3'h2;
  localparam logic [2:0] EAC_M_POSTINC = 3'h3;
  localparam logic [2:0] EAC_M_PREDEC = 3'h4;
  localparam logic [2:0] EAC_M_DISP = 3'h5;
  localparam logic [2:0] EAC_M_INDEX = 3'h6;
  localparam logic [2:0] EAC_M_SPECIAL = 3'h7;
  localparam logic [2:0] EAC_S_ABS_SHORT = 3'h0;
  localparam logic [2:0] EAC_S_ABS_LONG = 3'h1;
  localparam logic [2:0] EAC_S_PC_DISP = 3'h2;
  localparam logic [2:0] EAC_S_PC_INDEX = 3'h3;
  localparam logic [2:0] EAC_S_IMM = 3'h4;
  localparam logic [2:0] EAC_SP_NUM = 3'h7;
  localparam logic [1:0] EAC_BD_RSVD = 2'h0;
  localparam logic [1:0] EAC_BD_NULL = 2'h1;
  localparam logic [1:0] EAC_BD_WORD = 2'h2;
  localparam logic [1:0] EAC_BD_LONG = 2'h3;

  // ==========================================
  // reset values
  localparam logic [31:0] EAC_ZERO_WORD = 32'h0000_0000;

  // ==========================================
  // types
  typedef enum logic [1:0] {EAC_SZ_BYTE, EAC_SZ_WORD, EAC_SZ_LONG} eac_size_t;
  typedef enum logic [1:0] {EAC_LOC_DREG, EAC_LOC_AREG, EAC_LOC_MEM, EAC_LOC_IMM} eac_loc_t;
  typedef enum logic [3:0] {
    EAC_IMP_NONE, EAC_IMP_STATUS, EAC_IMP_FLOW, EAC_IMP_CALL, EAC_IMP_STACK,
    EAC_IMP_EXCEPTION, EAC_IMP_RET_STATUS, EAC_IMP_UNPRIV_MOVE
  } eac_implicit_t;

  typedef logic [15:0][31:0] eac_regs_t;

  typedef struct packed {
    logic [5:0] ea;
    eac_size_t size;
    logic write;
    logic jump;
    logic supervisor;
    eac_implicit_t implicit_op;
    logic [15:0] ext0;
    logic [15:0] ext1;
    logic [15:0] ext2;
    logic [31:0] ext_addr;
  } eac_req_t;

  typedef struct packed {
    eac_loc_t loc;
    logic [3:0] reg_num;
    logic [31:0] addr;
    logic program_space;
    logic read_only;
    logic [31:0] imm;
    logic [1:0] ext_used;
    logic illegal;
  } eac_res_t;

  typedef struct packed {
    logic en;
    logic [2:0] areg;
    logic [31:0] value;
  } eac_wb_t;

  typedef struct packed {
    logic pc;
    logic sp;
    logic priv_sp;
    logic unpriv_sp;
    logic state_word;
  } eac_imp_t;

endpackage
`default_nettype wire

// [rtl/eac_step_unit.sv]
`timescale 1ns/1ps
`default_nettype none
module eac_step_unit import eac_pkg::*; (
  // operand
  input wire eac_size_t size,
  input wire logic is_sp,
  // amount
  output logic [31:0] step
);
  // ==========================================
  // byte on sp steps two
  assign step = (size == EAC_SZ_LONG) ? 32'h0000_0004 :
                (size == EAC_SZ_WORD || is_sp) ? 32'h0000_0002 : 32'h0000_0001;
endmodule
`default_nettype wire

// [rtl/eac_index_unit.sv]
`timescale 1ns/1ps
`default_nettype none
module eac_index_unit import eac_pkg::*; (
  // extension word and register file
  input wire logic [15:0] ext,
  input wire eac_regs_t regs,
  // scaled index operand
  output logic [31:0] index_operand
);
  // ==========================================
  // data or address register
  wire [3:0] sel = {ext[EAC_IX_DA_BIT], ext[EAC_IX_NUM_HI:EAC_IX_NUM_LO]};
  wire [31:0] raw = regs[sel];
  wire [31:0] sized = ext[EAC_IX_LONG_BIT] ? raw : {{16{raw[15]}}, raw[15:0]};
  // scale by 1 2 4 8
  wire [1:0] scale = ext[EAC_IX_SCALE_HI:EAC_IX_SCALE_LO];
  assign index_operand = sized << scale;
endmodule
`default_nettype wire

// [rtl/eac_core.sv]
// Summary of operation
// - ea field splits into 3-bit mode and register subfields
// - register direct takes one of 16 registers, no memory access
// - plain indirect uses address register unchanged as address
// - postincrement uses register then adds 1, 2 or 4 by size
// - postincrement byte on stack pointer adds two
// - predecrement subtracts 1, 2 or 4 first, then uses result
// - predecrement byte on stack pointer subtracts two
// - displacement mode adds sign-extended 16-bit word to register
// - brief index sums register, sign-extended 8-bit disp and index
// - index bit 15 picks data or address, bits 14:12 number
// - index bit 11 picks sign-extended word or full long
// - index bits 10:9 scale by one, two, four or eight
// - indexed reference is data space except for jumps
// - full format adds base, index and optional sign-extended disp
// - pc displacement uses extension address, program space, reads only
// - pc brief index uses pc as base, program space reads
// - pc full index uses first extension address, read-only program
// - pc full index parts optional; suppressed base gives zero
// - absolute short sign-extends one extension word
// - absolute long joins first word high and second low
// - immediate byte, word, or long from two words high first
// - implicit pc, stack pointers and state word per instruction class
// - mode seven uses register field as submode selector
`timescale 1ns/1ps
`default_nettype none
module eac_core import eac_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_en,
  // request from decoder
  input wire logic req_valid,
  input wire eac_req_t req,
  // register file read view
  input wire eac_regs_t regs,
  // operand location
  output logic res_valid,
  output eac_res_t res,
  // address register update
  output eac_wb_t wb,
  // implicit registers
  output eac_imp_t imp
);

  // ==========================================
  // field decode
  // mode and register split
  wire [2:0] mode = req.ea[EAC_MODE_HI:EAC_MODE_LO];
  wire [2:0] rsel = req.ea[EAC_REG_HI:EAC_REG_LO];
  wire [31:0] areg = regs[{1'b1, rsel}];
  wire [15:0] ext0 = req.ext0;
  wire [15:0] ext1 = req.ext1;
  wire [15:0] ext2 = req.ext2;
  wire is_sp = (rsel == EAC_SP_NUM);

  // ==========================================
  // displacements
  // sign extend to 32 bits
  wire [31:0] disp16 = {{16{ext0[15]}}, ext0};
  wire [31:0] disp8 = {{24{ext0[7]}}, ext0[7:0]};
  wire [31:0] ext1_sext = {{16{ext1[15]}}, ext1};
  wire [31:0] ext01_long = {ext0, ext1};
  wire [31:0] ext12_long = {ext1, ext2};

  // ==========================================
  // index operand and step size
  wire [31:0] index_operand;
  wire [31:0] step;

  // one index unit serves both the register and the pc based forms
  eac_index_unit u_index (
    .ext(ext0),
    .regs(regs),
    .index_operand(index_operand)
  );

  eac_step_unit u_step (
    .size(req.size),
    .is_sp(is_sp),
    .step(step)
  );

  // ==========================================
  // indexed forms, shared by register and pc base
  wire full_fmt = ext0[EAC_FULL_BIT];
  wire base_sup = full_fmt & ext0[EAC_BASE_SUP_BIT];
  wire index_sup = full_fmt & ext0[EAC_IX_SUP_BIT];
  wire [1:0] bd_size = ext0[EAC_BD_HI:EAC_BD_LO];
  // memory indirection is not supported; any nonzero selector is refused
  wire full_bad = full_fmt & ((bd_size == EAC_BD_RSVD) |
                              (ext0[EAC_INDIR_HI:EAC_INDIR_LO] != 3'h0));
  // absent, word or long base displacement
  wire [31:0] base_disp = (bd_size == EAC_BD_WORD) ? ext1_sext :
                          (bd_size == EAC_BD_LONG) ? ext12_long : EAC_ZERO_WORD;
  wire [1:0] full_words = (bd_size == EAC_BD_WORD) ? 2'h2 :
                          (bd_size == EAC_BD_LONG) ? 2'h3 : 2'h1;
  wire [1:0] index_words = full_fmt ? full_words : 2'h1;
  wire [31:0] idx_disp = full_fmt ? base_disp : disp8;
  wire [31:0] idx_term = index_sup ? EAC_ZERO_WORD : index_operand;
  wire [31:0] areg_base = base_sup ? EAC_ZERO_WORD : areg;
  wire [31:0] pc_base = base_sup ? EAC_ZERO_WORD : req.ext_addr;
  wire [31:0] areg_index_addr = 32'(areg_base + idx_term + idx_disp);
  wire [31:0] pc_index_addr = 32'(pc_base + idx_term + idx_disp);

  // ==========================================
  // plain address forms
  // register unchanged
  wire [31:0] ind_addr = areg;
  wire [31:0] postinc_value = 32'(areg + step);
  // address and update come from one subtractor, so they cannot disagree
  // subtract before use
  wire [31:0] predec_value = 32'(areg - step);
  wire [31:0] disp_addr = 32'(areg + disp16);
  wire [31:0] pc_disp_addr = 32'(req.ext_addr + disp16);
  wire [31:0] abs_short = disp16;
  wire [31:0] abs_long = ext01_long;

  // ==========================================
  // immediate
  // byte, word, long
  wire [31:0] imm_value = (req.size == EAC_SZ_BYTE) ? {24'h00_0000, ext0[7:0]} :
                          (req.size == EAC_SZ_WORD) ? {16'h0000, ext0} : ext01_long;
  wire [1:0] imm_words = (req.size == EAC_SZ_LONG) ? 2'h2 : 2'h1;

  // ==========================================
  // refusals
  // pc-relative and immediate operands sit in the instruction stream, read only
  wire stream_operand = (mode == EAC_M_SPECIAL) &
                        ((rsel == EAC_S_PC_DISP) | (rsel == EAC_S_PC_INDEX) |
                         (rsel == EAC_S_IMM));
  wire bad_write = req.write & stream_operand;

  // ==========================================
  // operand location select
  eac_res_t next_res;
  eac_wb_t next_wb;

  always_comb begin
    next_res = '0;
    next_res.loc = EAC_LOC_MEM;
    next_res.reg_num = {1'b1, rsel};
    next_wb = '0;
    next_wb.areg = rsel;
    case (mode)
      EAC_M_DREG: begin
        next_res.loc = EAC_LOC_DREG;
        next_res.reg_num = {1'b0, rsel};
      end
      EAC_M_AREG: begin
        next_res.loc = EAC_LOC_AREG;
      end
      EAC_M_IND: begin
        next_res.addr = ind_addr;
      end
      EAC_M_POSTINC: begin
        next_res.addr = areg;
        next_wb.en = 1'b1;
        next_wb.value = postinc_value;
      end
      EAC_M_PREDEC: begin
        next_res.addr = predec_value;
        next_wb.en = 1'b1;
        next_wb.value = predec_value;
      end
      EAC_M_DISP: begin
        next_res.addr = disp_addr;
        next_res.ext_used = 2'h1;
      end
      EAC_M_INDEX: begin
        next_res.addr = areg_index_addr;
        next_res.ext_used = index_words;
        next_res.illegal = full_bad;
        next_res.program_space = req.jump;
      end
      EAC_M_SPECIAL: begin
        next_res.reg_num = 4'h0;
        case (rsel)
          EAC_S_ABS_SHORT: begin
            next_res.addr = abs_short;
            next_res.ext_used = 2'h1;
          end
          EAC_S_ABS_LONG: begin
            next_res.addr = abs_long;
            next_res.ext_used = 2'h2;
          end
          EAC_S_PC_DISP: begin
            next_res.addr = pc_disp_addr;
            next_res.ext_used = 2'h1;
            next_res.program_space = 1'b1;
            next_res.read_only = 1'b1;
          end
          EAC_S_PC_INDEX: begin
            next_res.addr = pc_index_addr;
            next_res.ext_used = index_words;
            next_res.program_space = 1'b1;
            next_res.read_only = 1'b1;
            next_res.illegal = full_bad;
          end
          EAC_S_IMM: begin
            next_res.loc = EAC_LOC_IMM;
            next_res.imm = imm_value;
            next_res.ext_used = imm_words;
            next_res.program_space = 1'b1;
            next_res.read_only = 1'b1;
          end
          default: begin
            next_res.illegal = 1'b1;
          end
        endcase
      end
      default: begin
        next_res.illegal = 1'b1;
      end
    endcase
    // a write to a read-only location is refused, and no side effect follows
    if (bad_write) begin
      next_res.illegal = 1'b1;
    end
    if (next_res.illegal) begin
      next_wb.en = 1'b0;
    end
  end

  // ==========================================
  // implicit register references
  // instruction class table
  eac_implicit_t iop;
  assign iop = req.implicit_op;
  wire imp_pc = (iop == EAC_IMP_FLOW) | (iop == EAC_IMP_CALL) |
                (iop == EAC_IMP_RET_STATUS);
  wire imp_sp = (iop == EAC_IMP_CALL) | (iop == EAC_IMP_STACK) |
                (iop == EAC_IMP_RET_STATUS);
  wire imp_word = (iop == EAC_IMP_STATUS) | (iop == EAC_IMP_EXCEPTION) |
                  (iop == EAC_IMP_RET_STATUS);
  // exceptions always stack on the privileged pointer, whatever the mode
  wire imp_priv = (iop == EAC_IMP_EXCEPTION) | (imp_sp & req.supervisor);
  wire imp_unpriv = (iop == EAC_IMP_UNPRIV_MOVE) | (imp_sp & ~req.supervisor);
  eac_imp_t next_imp;
  assign next_imp = '{pc: imp_pc, sp: imp_sp, priv_sp: imp_priv,
                      unpriv_sp: imp_unpriv, state_word: imp_word};

  // ==========================================
  // registered answer, one cycle after the request
  wire take = clock_en & req_valid;

  always_ff @(posedge clock) begin
    if (reset) begin
      res_valid <= 1'b0;
    end else if (clock_en) begin
      res_valid <= req_valid;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      res <= '0;
    end else if (take) begin
      res <= next_res;
    end
  end

  // implicit flags follow the same take, so they line up with res
  always_ff @(posedge clock) begin
    if (reset) begin
      imp <= '0;
    end else if (take) begin
      imp <= next_imp;
    end
  end

  // update strobe clears on the next enabled cycle, so it holds while clock_en is low and the register file applies it again
  always_ff @(posedge clock) begin
    if (reset) begin
      wb <= '0;
    end else if (take) begin
      wb <= next_wb;
    end else if (clock_en) begin
      wb.en <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [tb/eac_props.sv]
`timescale 1ns/1ps
`default_nettype none
module eac_props import eac_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_en,
  // request
  input wire logic req_valid,
  input wire eac_req_t req,
  input wire eac_regs_t regs,
  // result
  input wire logic res_valid,
  input wire eac_res_t res,
  input wire eac_wb_t wb,
  input wire eac_imp_t imp
);
  // ==========================================
  // copy of the taken request
  eac_req_t q;
  eac_regs_t qr;
  wire logic [2:0] m = q.ea[5:3];
  wire logic [2:0] n = q.ea[2:0];
  wire logic [31:0] an = qr[{1'b1, n}];
  wire logic [31:0] d16 = {{16{q.ext0[15]}}, q.ext0};
  wire logic [31:0] st = (q.size == EAC_SZ_LONG) ? 32'h4 :
    (q.size == EAC_SZ_WORD || n == EAC_SP_NUM) ? 32'h2 : 32'h1;
  always_ff @(posedge clock) begin
    if (clock_en && req_valid) begin
      q <= req;
      qr <= regs;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // ==========================================
  // properties
  a_answer_next: assert property (clock_en && req_valid |=> res_valid)
    else $error("no result after a taken request");
  a_no_spurious: assert property (clock_en && !req_valid |=> !res_valid)
    else $error("result without request");
  a_reg_direct: assert property (res_valid && m == EAC_M_DREG |->
    res.loc == EAC_LOC_DREG && res.reg_num == {1'b0, n}) else $error("bad data direct");
  a_plain_ind: assert property (res_valid && m == EAC_M_IND |->
    res.addr == an && !wb.en) else $error("bad indirect");
  a_postinc_step: assert property (res_valid && m == EAC_M_POSTINC |->
    res.addr == an && wb.en && wb.value == an + st) else $error("bad postincrement");
  a_predec_step: assert property (res_valid && m == EAC_M_PREDEC |->
    res.addr == an - st && wb.value == res.addr) else $error("bad predecrement");
  a_disp_sum: assert property (res_valid && m == EAC_M_DISP |->
    res.addr == an + d16) else $error("bad displacement");
  a_abs_short: assert property (res_valid && m == EAC_M_SPECIAL && n == EAC_S_ABS_SHORT |->
    res.addr == d16) else $error("bad absolute short");
  a_pc_disp: assert property (res_valid && m == EAC_M_SPECIAL && n == EAC_S_PC_DISP |->
    res.addr == q.ext_addr + d16 && res.program_space && res.read_only)
    else $error("bad pc displacement");
  a_wb_cause: assert property ($rose(wb.en) |-> $past(req_valid) && $past(clock_en))
    else $error("writeback without request");
  cover property (res_valid && wb.en);
  cover property (res_valid && res.loc == EAC_LOC_IMM);
  cover property (res_valid && !clock_en);
  cover property (imp.state_word && imp.priv_sp);
endmodule
bind eac_core eac_props i_props (.clock, .reset, .clock_en, .req_valid, .req, .regs,
  .res_valid, .res, .wb, .imp);
`default_nettype wire

// [tb/eac_regfile_model.sv]
`timescale 1ns/1ps
`default_nettype none
module eac_regfile_model import eac_pkg::*; (
  // clock
  input wire logic clock,
  // bench load
  input wire logic load_en,
  input wire eac_regs_t load_val,
  // core writeback
  input wire eac_wb_t wb,
  // register view
  output var eac_regs_t regs
);
  // writeback lands one edge after the pulse, as a real file would
  always_ff @(posedge clock) begin
    if (load_en) begin
      regs <= load_val;
    end else if (wb.en) begin
      regs[{1'b1, wb.areg}] <= wb.value;
    end
  end
endmodule
`default_nettype wire

// [tb/effective_address_calculator_test.sv]
`timescale 1ns/1ps
`default_nettype none
module effective_address_calculator_test import eac_pkg::*; ();
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic clock_en = 1'b1;
  logic req_valid = 1'b0;
  eac_req_t req = '0;
  logic load_en = 1'b0;
  eac_regs_t load_val = '0;
  eac_regs_t regs;
  logic res_valid;
  eac_res_t res;
  eac_wb_t wb;
  eac_imp_t imp;
  int err_total = 0;
  int comparisons = 0;
  integer seed = 69106;
  eac_req_t r;
  eac_regs_t g;
  always #10 clock = ~clock;
  eac_core i_dut (.clock, .reset, .clock_en, .req_valid, .req, .regs, .res_valid, .res,
    .wb, .imp);
  eac_regfile_model i_regs (.clock, .load_en, .load_val, .wb, .regs);
  // ==========================================
  // checking and expectations
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  function automatic logic [31:0] sx16(input logic [15:0] w);
    return {{16{w[15]}}, w};
  endfunction
  function automatic logic [31:0] stp(input eac_req_t q);
    if (q.size == EAC_SZ_LONG) return 32'h4;
    return (q.size == EAC_SZ_WORD || q.ea[2:0] == EAC_SP_NUM) ? 32'h2 : 32'h1;
  endfunction
  function automatic logic [31:0] exp_addr(input eac_req_t q, input eac_regs_t f);
    logic [2:0] m;
    logic [31:0] a;
    logic [31:0] x;
    logic [31:0] bd;
    m = q.ea[5:3];
    a = (m == EAC_M_SPECIAL) ? q.ext_addr : f[{1'b1, q.ea[2:0]}];
    x = f[{q.ext0[15], q.ext0[14:12]}];
    if (!q.ext0[11]) x = sx16(x[15:0]);
    x = x << q.ext0[10:9];
    bd = (q.ext0[5:4] == EAC_BD_WORD) ? sx16(q.ext1) :
      (q.ext0[5:4] == EAC_BD_LONG) ? {q.ext1, q.ext2} : 32'h0;
    if (m == EAC_M_PREDEC) return a - stp(q);
    if (m == EAC_M_DISP || (m == EAC_M_SPECIAL && q.ea[2:0] == EAC_S_PC_DISP)) begin
      return a + sx16(q.ext0);
    end
    if (m == EAC_M_SPECIAL && q.ea[2:0] == EAC_S_ABS_SHORT) return sx16(q.ext0);
    if (m == EAC_M_SPECIAL && q.ea[2:0] == EAC_S_ABS_LONG) return {q.ext0, q.ext1};
    if (m < EAC_M_INDEX) return a;
    // brief sums three terms, full drops suppressed parts
    if (!q.ext0[EAC_FULL_BIT]) return a + {{24{q.ext0[7]}}, q.ext0[7:0]} + x;
    return (q.ext0[7] ? 32'h0 : a) + (q.ext0[6] ? 32'h0 : x) + bd;
  endfunction
  function automatic eac_imp_t exp_imp(input eac_req_t q);
    logic [4:0] t;
    case (q.implicit_op)
      EAC_IMP_STATUS: t = 5'h01;
      EAC_IMP_FLOW: t = 5'h10;
      EAC_IMP_CALL: t = 5'h18;
      EAC_IMP_STACK: t = 5'h08;
      EAC_IMP_EXCEPTION: t = 5'h05;
      EAC_IMP_RET_STATUS: t = 5'h19;
      EAC_IMP_UNPRIV_MOVE: t = 5'h02;
      default: t = 5'h00;
    endcase
    if (t[3]) t = t | (q.supervisor ? 5'h04 : 5'h02);
    return t;
  endfunction
  function automatic logic exp_bad(input eac_req_t q);
    logic [2:0] m;
    logic [2:0] s;
    logic full;
    m = q.ea[5:3];
    s = q.ea[2:0];
    full = q.ext0[EAC_FULL_BIT] && (m == EAC_M_INDEX || (m == EAC_M_SPECIAL && s == EAC_S_PC_INDEX));
    if (m == EAC_M_SPECIAL && s > EAC_S_IMM) return 1'b1;
    // stream operands are read only, so a write to them is refused
    if (q.write && m == EAC_M_SPECIAL && s >= EAC_S_PC_DISP) return 1'b1;
    return full && (q.ext0[5:4] == EAC_BD_RSVD || q.ext0[2:0] != 3'h0);
  endfunction
  function automatic logic [1:0] exp_words(input eac_req_t q);
    logic [2:0] m;
    logic [2:0] s;
    m = q.ea[5:3];
    s = q.ea[2:0];
    if (m == EAC_M_DISP) return 2'h1;
    if (m == EAC_M_INDEX || (m == EAC_M_SPECIAL && s == EAC_S_PC_INDEX)) begin
      if (!q.ext0[EAC_FULL_BIT]) return 2'h1;
      if (q.ext0[5:4] == EAC_BD_WORD) return 2'h2;
      return (q.ext0[5:4] == EAC_BD_LONG) ? 2'h3 : 2'h1;
    end
    if (m != EAC_M_SPECIAL) return 2'h0;
    if (s == EAC_S_ABS_LONG || (s == EAC_S_IMM && q.size == EAC_SZ_LONG)) return 2'h2;
    return 2'h1;
  endfunction
  // ==========================================
  // stimulus
  task automatic rand_req();
    logic [95:0] v;
    v = {$random(seed), $random(seed), $random(seed)};
    for (int i = 0; i < 16; i++) g[i] = $random(seed);
    r = v[$bits(eac_req_t)-1:0];
    r.write = 1'b0;
    if (r.size > EAC_SZ_LONG) r.size = EAC_SZ_WORD;
    if (r.ea[5:3] == EAC_M_SPECIAL && r.ea[2:0] > EAC_S_IMM) r.ea[2:0] = EAC_S_IMM;
    // reserved displacement size and memory indirection are kept out
    if (r.ext0[8]) r.ext0[3:0] = 4'h0;
    if (r.ext0[8] && r.ext0[5:4] == EAC_BD_RSVD) r.ext0[5:4] = EAC_BD_LONG;
  endtask
  task automatic run(input logic stall);
    logic [2:0] m;
    logic [3:0] k;
    logic sub_bad;
    logic pc_rel;
    m = r.ea[5:3];
    k = {1'b1, r.ea[2:0]};
    sub_bad = m == EAC_M_SPECIAL && r.ea[2:0] > EAC_S_IMM;
    pc_rel = m == EAC_M_SPECIAL && r.ea[2:1] == 2'h1;
    @(posedge clock);
    load_en <= 1'b1;
    load_val <= g;
    @(posedge clock);
    load_en <= 1'b0;
    req_valid <= 1'b1;
    req <= r;
    @(posedge clock);
    req_valid <= 1'b0;
    clock_en <= !stall;
    #1;
    check(res_valid, 1'b1);
    check(imp, exp_imp(r));
    check(res.illegal, exp_bad(r));
    if (!sub_bad) check(res.ext_used, exp_words(r));
    if (sub_bad) begin
      check(wb.en, 1'b0);
    end else if (m < EAC_M_IND) begin
      check(res.loc, m[0] ? EAC_LOC_AREG : EAC_LOC_DREG);
      check(res.reg_num, {m[0], r.ea[2:0]});
    end else if (m == EAC_M_SPECIAL && r.ea[2:0] == EAC_S_IMM) begin
      check(res.loc, EAC_LOC_IMM);
      check(res.imm, (r.size == EAC_SZ_LONG) ? {r.ext0, r.ext1} : (r.size == EAC_SZ_WORD) ?
        {16'h0, r.ext0} : {24'h0, r.ext0[7:0]});
      check(res.program_space, 1'b1);
      check(res.read_only, 1'b1);
    end else begin
      check(res.addr, exp_addr(r, g));
      check(res.program_space, pc_rel || (m == EAC_M_INDEX && r.jump));
      check(res.read_only, pc_rel);
      check(wb.en, m == EAC_M_POSTINC || m == EAC_M_PREDEC);
    end
    @(posedge clock);
    clock_en <= 1'b1;
    #1;
    check(res_valid, stall);
    @(posedge clock);
    #1;
    check(res_valid, 1'b0);
    if (m == EAC_M_POSTINC) check(regs[k], g[k] + stp(r));
    if (m == EAC_M_PREDEC) check(regs[k], exp_addr(r, g));
  endtask
  initial begin
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    for (int i = 0; i < 300; i++) begin
      rand_req();
      r.implicit_op = eac_implicit_t'(i % 8);
      run(i % 7 == 0);
    end
    $display("random test done");
    @(posedge clock);
    reset <= 1'b1;
    @(posedge clock);
    reset <= 1'b0;
    #1;
    check(res_valid, 1'b0);
    check(wb.en, 1'b0);
    check(res.addr, 32'h0);
    check(imp, 32'h0);
    rand_req();
    r.ea = {EAC_M_POSTINC, EAC_SP_NUM};
    r.size = EAC_SZ_BYTE;
    run(1'b1);
    r.ea = {EAC_M_PREDEC, EAC_SP_NUM};
    run(1'b0);
    r.ea = {EAC_M_PREDEC, 3'h0};
    r.size = EAC_SZ_LONG;
    g[8] = 32'h0;
    run(1'b0);
    r.ea = {EAC_M_SPECIAL, EAC_S_PC_INDEX};
    r.ext0 = 16'h1d90;
    run(1'b0);
    r.ea = {EAC_M_SPECIAL, EAC_S_PC_DISP};
    r.write = 1'b1;
    run(1'b0);
    r.ea = {EAC_M_SPECIAL, EAC_S_IMM};
    run(1'b1);
    r.ea = {EAC_M_INDEX, 3'h2};
    r.write = 1'b0;
    r.jump = 1'b1;
    r.ext0 = 16'h9b03;
    run(1'b0);
    r.ea = {EAC_M_SPECIAL, 3'h5};
    run(1'b0);
    $display("corner test done");
    give_verdict();
  end
  initial begin
    #200000;
    err_total++;
    $display("Error at %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule
`default_nettype wire
